/* core/hos_pkg.sv */
// Shared constants and types for the heat-seal output supervisor.
// Assumes a single 20 MHz clock and a synchronous active-high reset.
// Function
// RL1: Normal polarity closes alarm contact on fault.
// RL2: Inverse polarity opens alarm contact on fault.
// RL3: Analog output selects live value or reference.
// RL4: Diagnosis raises 307/308 when leaving band.
// RL5: Diagnosis delay starts on entering band.
// RL6: Timeout and diagnosis fault wait for delay.
// RL7: Delay setting changeable only with diagnosis on.
// RL8: Heat-up timeout raises 304 outside band.
// RL9: Measuring impulse 1.7 to 3.0 ms, special variant.
// RL10: Off setting keeps general output de-energized.
// RL11: In-band setting energizes output inside band.
// RL12: Latched in-band output cleared by next start.
// RL13: Start-follow output on start, off cooling end.
// RL14: Reached output on 95 percent, off cooling end.
// RL15: Cooling output from heating end to cooling end.
// RL16: End-of-cycle pulse at most 0.5 seconds.
// RL17: Start during pulse ends it early.
// RL18: Unit setting selects Celsius or Fahrenheit.
// RL19: Timers share one 0.1 second tick; the end-of-cycle pulse counts clock cycles instead.
package hos_pkg;

  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_TIME_MS  = 100;
  localparam int TICK_CYC      = TICK_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int EOC_TIME_MS   = 500;
  localparam int EOC_CYC       = EOC_TIME_MS * 1000000 / CLK_PERIOD_NS;

  localparam int DW = 10;                      // Tenths of seconds, 0..99.9 s
  localparam logic [DW-1:0] TIME_MAX  = 10'h3E7; // 99.9 s
  localparam logic [DW-1:0] CODE_NONE = 10'h000;
  localparam logic [DW-1:0] CODE_HEAT = 10'h130; // 304
  localparam logic [DW-1:0] CODE_LOW  = 10'h133; // 307
  localparam logic [DW-1:0] CODE_HIGH = 10'h134; // 308

  localparam int MW = 5;                       // Impulse length in 0.1 ms
  localparam logic [MW-1:0] MEAS_MIN = 5'h11;  // 1.7 ms
  localparam logic [MW-1:0] MEAS_MAX = 5'h1E;  // 3.0 ms

  typedef enum logic [2:0] {
    MODE_OFF   = 3'h0,
    MODE_BAND  = 3'h1,
    MODE_LATCH = 3'h2,
    MODE_START = 3'h3,
    MODE_REACH = 3'h4,
    MODE_COOL  = 3'h5,
    MODE_EOC   = 3'h6
  } hos_mode_t;

endpackage : hos_pkg

/* core/hos_in_stage.sv */
// Start pin synchroniser and the shared 0.1 s time base.
// Start arrives asynchronously from the sequencer; tick is internal.
`timescale 1ns/1ps
module hos_in_stage #(
  parameter int TICK_CYC = hos_pkg::TICK_CYC
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic start_pin,
  output logic      start_lvl,
  output logic      start_rise,
  output logic      tick
);
  import hos_pkg::*;

  localparam int TW = $clog2(TICK_CYC + 1);

  typedef struct packed {
    logic [2:0]    sync;
    logic          lvl;
    logic          rise;
    logic [TW-1:0] tcnt;
    logic          tick;
  } hos_in_st_t;

  hos_in_st_t q, d;

  // Level only changes once second and third stages agree
  always_comb begin
    d      = q;
    d.sync = {q.sync[1:0], start_pin};
    d.rise = 1'b0;
    if (q.sync[1] == q.sync[2]) begin
      d.lvl  = q.sync[2];
      d.rise = q.sync[2] & ~q.lvl;
    end
    // Free-running divider, one pulse every 0.1 s [RL19]
    d.tick = 1'b0;
    if (q.tcnt == TW'(TICK_CYC - 1)) begin
      d.tcnt = '0;
      d.tick = 1'b1;
    end else begin
      d.tcnt = q.tcnt + TW'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign start_lvl  = q.lvl;
  assign start_rise = q.rise;
  assign tick       = q.tick;

endmodule : hos_in_stage

/* core/hos_top.sv */
// Alarm relay, general output and temperature supervision timers.
// Band, 95 percent, heating end and cooling end come from the control
// loop on this clock; start comes from the sequencer pin.
`timescale 1ns/1ps
module hos_top #(
  parameter int TICK_CYC = hos_pkg::TICK_CYC,
  parameter int EOC_CYC  = hos_pkg::EOC_CYC
) (
  input  wire logic                     clock,
  input  wire logic                     rst,
  input  wire logic                     start_pin,
  input  wire logic                     in_band,
  input  wire logic                     temp_high,
  input  wire logic                     temp_reached,
  input  wire logic                     heat_end,
  input  wire logic                     cool_end,
  input  wire logic                     ext_fault,
  input  wire logic                     time_ctrl,
  input  wire hos_pkg::hos_mode_t       out1_mode,
  input  wire logic                     alarm_inverse,
  input  wire logic                     analog_ref_cfg,
  input  wire logic                     unit_fahr_cfg,
  input  wire logic                     diag_en,
  input  wire logic [hos_pkg::DW-1:0]   diag_delay_cfg,
  input  wire logic                     heatup_en,
  input  wire logic [hos_pkg::DW-1:0]   heatup_cfg,
  input  wire logic                     special_variant,
  input  wire logic [hos_pkg::MW-1:0]   meas_len_cfg,
  output logic                          alarm_relay,
  output logic                          out1,
  output logic                          analog_ref,
  output logic                          unit_fahr,
  output logic                          delay_edit_en,
  output logic [hos_pkg::DW-1:0]        diag_delay,
  output logic [hos_pkg::MW-1:0]        meas_len,
  output logic                          fault_active,
  output logic [hos_pkg::DW-1:0]        fault_code
);
  import hos_pkg::*;

  localparam int EW = $clog2(EOC_CYC + 1);

  typedef struct packed {
    logic          alarm;
    logic          out1;
    logic          ref_sel;
    logic          fahr;
    logic          edit_en;
    logic [DW-1:0] dly_set;
    logic [MW-1:0] meas;
    logic          fault;
    logic [DW-1:0] code;
    logic          band;
    logic          armed;
    logic          dly_run;
    logic [DW-1:0] dly_cnt;
    logic          hu_run;
    logic [DW-1:0] hu_cnt;
    logic          latch;
    logic          hold;
    logic          eoc;
    logic [EW-1:0] eoc_cnt;
  } hos_top_st_t;

  hos_top_st_t q, d;

  logic start_lvl;
  logic start_rise;
  logic tick;

  // Limit a time setting to the 99.9 s range
  function automatic logic [DW-1:0] clamp_time(input logic [DW-1:0] v);
    clamp_time = (v > TIME_MAX) ? TIME_MAX : v;
  endfunction : clamp_time

  // Keep the impulse length inside 1.7..3.0 ms
  function automatic logic [MW-1:0] clamp_meas(input logic [MW-1:0] v);
    if (v < MEAS_MIN) begin
      clamp_meas = MEAS_MIN;
    end else if (v > MEAS_MAX) begin
      clamp_meas = MEAS_MAX;
    end else begin
      clamp_meas = v;
    end
  endfunction : clamp_meas

  hos_in_stage #(
    .TICK_CYC (TICK_CYC)
  ) u_in (
    .clock      (clock),
    .rst        (rst),
    .start_pin  (start_pin),
    .start_lvl  (start_lvl),
    .start_rise (start_rise),
    .tick       (tick)
  );

  logic [DW-1:0] hu_lim;
  assign hu_lim = clamp_time(heatup_cfg);

  always_comb begin
    d = q;

    // Plain configuration mirrors
    d.ref_sel = analog_ref_cfg;                    // [RL3]
    d.fahr    = unit_fahr_cfg;                     // [RL18]
    d.edit_en = diag_en;
    if (diag_en) begin
      d.dly_set = clamp_time(diag_delay_cfg);      // [RL7]
    end
    // Standard units run the shortest impulse only
    d.meas = special_variant ? clamp_meas(meas_len_cfg) : MEAS_MIN; // [RL9]

    // Faults from the last cycle clear on a new start
    if (start_rise) begin
      d.fault = 1'b0;
      d.code  = CODE_NONE;
    end

    // Delay restarts each time the value enters the band
    d.band = in_band;
    if (start_rise || !diag_en) begin
      d.armed = 1'b0;
    end
    if (!in_band) begin
      d.dly_run = 1'b0;
    end else if (!q.band) begin
      d.dly_run = 1'b1;                            // [RL5]
      d.dly_cnt = '0;
    end else if (q.dly_run) begin
      if (q.dly_cnt >= q.dly_set) begin
        d.dly_run = 1'b0;
        d.armed   = diag_en;                       // [RL6]
      end else if (tick) begin
        d.dly_cnt = q.dly_cnt + DW'(1);            // [RL19]
      end
    end

    // Heat-up timer runs from start; zero time reads as off
    if (start_rise) begin
      d.hu_run = heatup_en && (hu_lim != '0);
      d.hu_cnt = '0;
    end else if (q.hu_run) begin
      if (q.hu_cnt >= hu_lim) begin
        d.hu_run = 1'b0;
        // Held back while the diagnosis delay is still open
        if (!in_band && (!diag_en || q.armed)) begin
          d.fault = 1'b1;                          // [RL8] [RL6]
          d.code  = CODE_HEAT;
        end
      end else if (tick) begin
        d.hu_cnt = q.hu_cnt + DW'(1);              // [RL19]
      end
    end

    // Leaving the band after the delay is a diagnosis fault. Taken on the
    // exit edge only, so a new start can clear it while still out of band;
    // placed after the heat-up check so its code wins a tie
    if (diag_en && q.armed && q.band && !in_band) begin
      d.fault = 1'b1;                              // [RL4]
      d.code  = temp_high ? CODE_HIGH : CODE_LOW;
    end

    // Latch sets inside band; new start clears but set wins
    if (start_rise) begin
      d.latch = 1'b0;
    end
    if (in_band) begin
      d.latch = 1'b1;                              // [RL12]
    end

    // Phase-tied hold, released at cooling end
    if (cool_end) begin
      d.hold = 1'b0;
    end
    case (out1_mode)
      MODE_START: begin
        if (start_lvl) d.hold = 1'b1;              // [RL13]
      end
      MODE_REACH: begin
        if (temp_reached) d.hold = 1'b1;           // [RL14]
      end
      MODE_COOL: begin
        if (heat_end) d.hold = 1'b1;               // [RL15]
      end
      default: begin
        d.hold = 1'b0;
      end
    endcase
    if (!time_ctrl) begin
      d.hold = 1'b0;
    end

    // End-of-cycle pulse; start cuts it short
    if (q.eoc) begin
      if (start_lvl || q.eoc_cnt == EW'(EOC_CYC - 1)) begin
        d.eoc = 1'b0;                              // [RL16] [RL17]
      end else begin
        d.eoc_cnt = q.eoc_cnt + EW'(1);
      end
    end else if (cool_end && time_ctrl && out1_mode == MODE_EOC) begin
      d.eoc     = !start_lvl;
      d.eoc_cnt = '0;
    end

    // General output selection
    case (out1_mode)
      MODE_OFF:   d.out1 = 1'b0;                   // [RL10]
      MODE_BAND:  d.out1 = in_band;                // [RL11]
      MODE_LATCH: d.out1 = d.latch;                // [RL12]
      MODE_START: d.out1 = d.hold;
      MODE_REACH: d.out1 = d.hold;
      MODE_COOL:  d.out1 = d.hold;
      MODE_EOC:   d.out1 = d.eoc;
      default:    d.out1 = 1'b0;
    endcase

    // Contact follows the fault, flipped for inverse wiring
    d.alarm = (d.fault | ext_fault) ^ alarm_inverse; // [RL1] [RL2]
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      q       <= '0;
      q.meas  <= MEAS_MIN;
      q.code  <= CODE_NONE;
    end else begin
      q <= d;
    end
  end

  assign alarm_relay   = q.alarm;
  assign out1          = q.out1;
  assign analog_ref    = q.ref_sel;
  assign unit_fahr     = q.fahr;
  assign delay_edit_en = q.edit_en;
  assign diag_delay    = q.dly_set;
  assign meas_len      = q.meas;
  assign fault_active  = q.fault;
  assign fault_code    = q.code;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_diag_trip;
    diag_en && q.armed && q.band && !in_band;
  endsequence

  sequence s_eoc_go;
    !q.eoc && cool_end && time_ctrl && out1_mode == MODE_EOC && !start_lvl;
  endsequence

  sequence s_eoc_cut;
    q.eoc && start_lvl;
  endsequence

  AST_ALARM_NORMAL: assert property ( // [RL1]
    ##1 !$past(alarm_inverse) |-> alarm_relay == (fault_active | $past(ext_fault)))
    else $error("alarm contact not closed on fault");

  AST_ALARM_INVERSE: assert property ( // [RL2]
    ##1 $past(alarm_inverse) |-> alarm_relay == !(fault_active | $past(ext_fault)))
    else $error("alarm contact not opened on fault");

  AST_ANALOG_SEL: assert property ( // [RL3]
    ##1 1'b1 |-> analog_ref == $past(analog_ref_cfg))
    else $error("analog output selection not followed");

  AST_DIAG_FAULT: assert property ( // [RL4]
    s_diag_trip |=> fault_active && (fault_code == CODE_LOW || fault_code == CODE_HIGH))
    else $error("diagnosis fault code missing");

  AST_DELAY_START: assert property ( // [RL5]
    in_band && !q.band && !q.armed |=> q.dly_run && q.dly_cnt == '0)
    else $error("diagnosis delay did not start on band entry");

  AST_DELAY_HOLD: assert property ( // [RL6]
    diag_en && q.dly_run && q.dly_cnt < q.dly_set && !start_rise
    |=> !fault_active || $past(fault_active))
    else $error("fault raised during diagnosis delay");

  AST_DELAY_LOCK: assert property ( // [RL7]
    !diag_en |=> $stable(diag_delay))
    else $error("delay changed with diagnosis off");

  AST_HEATUP: assert property ( // [RL8]
    q.hu_run && q.hu_cnt >= hu_lim && !in_band && !diag_en && !start_rise
    |=> fault_active && fault_code == CODE_HEAT)
    else $error("heat-up timeout fault missing");

  AST_MEAS_RANGE: assert property ( // [RL9]
    meas_len >= MEAS_MIN && meas_len <= MEAS_MAX)
    else $error("impulse length outside range");

  AST_OUT_OFF: assert property ( // [RL10]
    out1_mode == MODE_OFF |=> !out1)
    else $error("output energized in off setting");

  AST_OUT_BAND: assert property ( // [RL11]
    out1_mode == MODE_BAND |=> out1 == $past(in_band))
    else $error("in-band output wrong");

  AST_EOC_PULSE: assert property ( // [RL16]
    s_eoc_go |=> out1)
    else $error("end-of-cycle pulse not started");

  AST_EOC_CUT: assert property ( // [RL17]
    s_eoc_cut |=> !q.eoc)
    else $error("start did not cut end-of-cycle pulse");

  // Unit and output-mode checks: each cause shows on unit_fahr or out1 one edge later
  sequence s_latch_set;
    out1_mode == MODE_LATCH && (in_band || (q.latch && !start_rise));
  endsequence

  sequence s_latch_clear;
    out1_mode == MODE_LATCH && start_rise && !in_band;
  endsequence

  AST_UNIT_SEL: assert property ( // [RL18]
    ##1 1'b1 |-> unit_fahr == $past(unit_fahr_cfg))
    else $error("temperature unit selection not followed");

  AST_LATCH_HOLD: assert property ( // [RL12]
    s_latch_set |=> out1)
    else $error("latched output dropped before next start");

  AST_LATCH_CLEAR: assert property ( // [RL12]
    s_latch_clear |=> !out1)
    else $error("latched output not cleared by start");

  AST_START_ON: assert property ( // [RL13]
    time_ctrl && out1_mode == MODE_START && start_lvl |=> out1)
    else $error("start-follow output not energized");

  AST_START_OFF: assert property ( // [RL13]
    time_ctrl && out1_mode == MODE_START && cool_end && !start_lvl |=> !out1)
    else $error("start-follow output not released at cooling end");

  AST_REACH_ON: assert property ( // [RL14]
    time_ctrl && out1_mode == MODE_REACH && temp_reached |=> out1)
    else $error("temperature-reached output not energized");

  AST_REACH_OFF: assert property ( // [RL14]
    time_ctrl && out1_mode == MODE_REACH && cool_end && !temp_reached |=> !out1)
    else $error("temperature-reached output not released at cooling end");

  AST_COOL_ON: assert property ( // [RL15]
    time_ctrl && out1_mode == MODE_COOL && heat_end |=> out1)
    else $error("cooling output not energized at heating end");

  AST_COOL_OFF: assert property ( // [RL15]
    time_ctrl && out1_mode == MODE_COOL && cool_end && !heat_end |=> !out1)
    else $error("cooling output not released at cooling end");

  AST_TICK_PULSE: assert property ( // [RL19]
    tick |=> !tick)
    else $error("time base tick longer than one cycle");

endmodule : hos_top

/* sim/hos_seq_model.sv */
// Packaging sequencer model: drives the start pin, watches out1.
// Assumes the bench requests a press with a one-cycle pulse.
`timescale 1ns/1ps
module hos_seq_model (
  input  wire logic clock,
  input  wire logic press,
  input  wire logic cut,
  input  wire logic out1,
  output logic      start_pin
);
  int   hold     = 0;
  int   wait_n   = 0;
  logic out1_was = 1'b0;
  logic drive_q  = 1'b0;
  initial start_pin = 1'b0;
  // Press and out1 are read on the rising edge, where both are settled,
  // so a press that the bench sets on a falling edge is never raced
  always @(posedge clock) begin
    out1_was <= out1;
    if (cut && out1 && !out1_was) wait_n <= 5;  // Shorten a pulse
    else if (wait_n > 0) wait_n <= wait_n - 1;
    if (press || wait_n == 1) hold <= 6;
    else if (hold > 0) hold <= hold - 1;
    drive_q <= press || wait_n == 1 || hold > 1;
  end
  // Start held six cycles so the three-stage pin filter sees it; the pin
  // moves on the falling edge like every other input
  always @(negedge clock) start_pin <= drive_q;
endmodule : hos_seq_model

/* sim/hos_top_bench.sv */
// Self-checking bench for the heat-seal output supervisor.
// Assumes short tick and pulse counts; inputs change on falling edges.
`timescale 1ns/1ps
module hos_top_bench;
  import hos_pkg::*;
  localparam int TK = 10;
  localparam int EC = 40;
  logic clock = 1'b0, rst = 1'b1, press = 1'b0, cut = 1'b0, start_pin;
  logic in_band = 1'b0, temp_high = 1'b0, temp_reached = 1'b0;
  logic heat_end = 1'b0, cool_end = 1'b0, ext_fault = 1'b0, time_ctrl = 1'b0;
  logic alarm_inverse = 1'b0, analog_ref_cfg = 1'b0, unit_fahr_cfg = 1'b0;
  logic diag_en = 1'b0, heatup_en = 1'b0, special_variant = 1'b0;
  logic [DW-1:0] diag_delay_cfg = '0, heatup_cfg = '0, diag_delay, fault_code;
  logic [MW-1:0] meas_len_cfg = 5'h14, meas_len;
  hos_mode_t out1_mode = MODE_OFF;
  logic alarm_relay, out1, analog_ref, unit_fahr, delay_edit_en, fault_active;
  int n_mismatch = 0, compares = 0, i;

  hos_seq_model SEQ (.clock(clock), .press(press), .cut(cut), .out1(out1),
                     .start_pin(start_pin));
  hos_top #(.TICK_CYC(TK), .EOC_CYC(EC)) DUT (
    .clock(clock), .rst(rst), .start_pin(start_pin), .in_band(in_band),
    .temp_high(temp_high), .temp_reached(temp_reached), .heat_end(heat_end),
    .cool_end(cool_end), .ext_fault(ext_fault), .time_ctrl(time_ctrl),
    .out1_mode(out1_mode), .alarm_inverse(alarm_inverse),
    .analog_ref_cfg(analog_ref_cfg), .unit_fahr_cfg(unit_fahr_cfg),
    .diag_en(diag_en), .diag_delay_cfg(diag_delay_cfg), .heatup_en(heatup_en),
    .heatup_cfg(heatup_cfg), .special_variant(special_variant),
    .meas_len_cfg(meas_len_cfg), .alarm_relay(alarm_relay), .out1(out1),
    .analog_ref(analog_ref), .unit_fahr(unit_fahr),
    .delay_edit_en(delay_edit_en), .diag_delay(diag_delay),
    .meas_len(meas_len), .fault_active(fault_active), .fault_code(fault_code));

  // Free-running 20 MHz clock
  initial forever #25 clock = ~clock;

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc

  task automatic chk(input logic [DW-1:0] s, input logic [DW-1:0] e);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic conclude;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude

  // A used-up wait bound counts as a failure and ends the run
  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      n_mismatch++;
      conclude();
    end
  endtask : tmo

  task automatic pulse_cool;
    cool_end = 1'b1;
    cyc(1);
    cool_end = 1'b0;
  endtask : pulse_cool

  task automatic t_config;
    cyc(2);
    chk(meas_len, MEAS_MIN);
    chk(alarm_relay, 1'b0);
    special_variant = 1'b1; analog_ref_cfg = 1'b1; unit_fahr_cfg = 1'b1;
    alarm_inverse = 1'b1;
    cyc(3);
    chk(meas_len, 5'h14);
    chk(analog_ref, 1'b1);
    chk(unit_fahr, 1'b1);
    chk(alarm_relay, 1'b1);
    ext_fault = 1'b1;
    cyc(3);
    chk(alarm_relay, 1'b0);
    alarm_inverse = 1'b0;
    cyc(3);
    chk(alarm_relay, 1'b1);
    ext_fault = 1'b0; analog_ref_cfg = 1'b0; unit_fahr_cfg = 1'b0;
    cyc(3);
    chk(analog_ref, 1'b0);
    chk(unit_fahr, 1'b0);
    $display("test config done");
  endtask : t_config

  task automatic t_modes;
    in_band = 1'b1;
    cyc(3);
    chk(out1, 1'b0);
    out1_mode = MODE_BAND;
    cyc(3);
    chk(out1, 1'b1);
    out1_mode = MODE_LATCH;
    cyc(2);
    in_band = 1'b0;
    cyc(3);
    chk(out1, 1'b1);
    press = 1'b1; cyc(1); press = 1'b0; cyc(8);
    chk(out1, 1'b0);
    time_ctrl = 1'b1; out1_mode = MODE_START;
    press = 1'b1; cyc(1); press = 1'b0; cyc(5);
    chk(out1, 1'b1);
    cyc(8);
    chk(out1, 1'b1);
    pulse_cool(); cyc(2);
    chk(out1, 1'b0);
    out1_mode = MODE_REACH;
    temp_reached = 1'b1; cyc(1); temp_reached = 1'b0; cyc(4);
    chk(out1, 1'b1);
    pulse_cool(); cyc(2);
    chk(out1, 1'b0);
    out1_mode = MODE_COOL;
    heat_end = 1'b1; cyc(1); heat_end = 1'b0; cyc(4);
    chk(out1, 1'b1);
    pulse_cool(); cyc(2);
    chk(out1, 1'b0);
    out1_mode = MODE_EOC;
    pulse_cool();
    for (i = 0; i < 5 && out1 !== 1'b1; i++) cyc(1);
    tmo(i, 5);
    for (i = 0; i < 100 && out1 === 1'b1; i++) cyc(1);
    chk(i, EC);
    cut = 1'b1;
    pulse_cool();
    for (i = 0; i < 100 && out1 !== 1'b0; i++) cyc(1);
    chk(i > 5 && i < 20, 1'b1);
    cut = 1'b0; out1_mode = MODE_OFF; time_ctrl = 1'b0;
    cyc(10);
    $display("test modes done");
  endtask : t_modes

  task automatic t_diag;
    diag_delay_cfg = 10'h005;
    cyc(3);
    chk(delay_edit_en, 1'b0);
    chk(diag_delay, 10'h000);
    diag_en = 1'b1;
    cyc(3);
    chk(delay_edit_en, 1'b1);
    diag_delay_cfg = 10'h003;
    cyc(3);
    chk(diag_delay, 10'h003);
    in_band = 1'b1; cyc(10); in_band = 1'b0; cyc(5);
    chk(fault_active, 1'b0);
    in_band = 1'b1; cyc(50); temp_high = 1'b1; in_band = 1'b0; cyc(3);
    chk(fault_active, 1'b1);
    chk(fault_code, CODE_HIGH);
    chk(alarm_relay, 1'b1);
    press = 1'b1; cyc(1); press = 1'b0; cyc(8);
    chk(fault_active, 1'b0);
    temp_high = 1'b0;
    in_band = 1'b1; cyc(50); in_band = 1'b0; cyc(3);
    chk(fault_code, CODE_LOW);
    diag_en = 1'b0;
    press = 1'b1; cyc(1); press = 1'b0; cyc(8);
    $display("test diag done");
  endtask : t_diag

  task automatic t_heatup;
    heatup_en = 1'b1; heatup_cfg = 10'h003;
    press = 1'b1; cyc(1); press = 1'b0; cyc(10);
    chk(fault_active, 1'b0);
    for (i = 0; i < 60 && fault_active !== 1'b1; i++) cyc(1);
    tmo(i, 60);
    chk(fault_code, CODE_HEAT);
    $display("test heatup done");
  endtask : t_heatup

  // Main sequence: reset, then each scenario in turn
  initial begin
    cyc(20);
    rst = 1'b0;
    t_config();
    t_modes();
    t_diag();
    t_heatup();
    conclude();
  end
endmodule : hos_top_bench
